/* File: inc/mctc_defs.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * machine-cycle timer/counter block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`ifndef MCTC_DEFS_SVH
`define MCTC_DEFS_SVH

// Register byte offsets
`define MCTC_OFF_CTRL 12'h000
`define MCTC_OFF_MODE 12'h004
`define MCTC_OFF_T2CTRL 12'h008
`define MCTC_OFF_CNT0 12'h00C
`define MCTC_OFF_CNT1 12'h010
`define MCTC_OFF_CNT2 12'h014
`define MCTC_OFF_RCAP 12'h018
`define MCTC_OFF_CLKDIV 12'h01C

// Control register fields
`define MCTC_CTRL_RUN0 0
`define MCTC_CTRL_RUN1 1
`define MCTC_CTRL_OVF0 4
`define MCTC_CTRL_OVF1 5

// Mode register: timer 0 in bits 3:0, timer 1 in bits 7:4
`define MCTC_MODE_M_LO 0
`define MCTC_MODE_CT 2
`define MCTC_MODE_GATE 3
`define MCTC_MODE_T1_BASE 4

// Third-timer control fields
`define MCTC_T2_CAP 0
`define MCTC_T2_CT 1
`define MCTC_T2_RUN 2
`define MCTC_T2_EXEN 3
`define MCTC_T2_TBAUD 4
`define MCTC_T2_RBAUD 5
`define MCTC_T2_EXF 6
`define MCTC_T2_OVF 7

// Reset values
`define MCTC_RST_BYTE 8'h00
`define MCTC_RST_DIV 3'h3

// Machine cycle timing
`define MCTC_CORE_PER_MC 12
`define MCTC_PH_SAMPLE 4'h9
`define MCTC_PH_UPDATE 4'h4

`endif

/* File: inc/mctc_pkg.sv */
/*
 * Types of the machine-cycle timer/counter block.
 * Assumes mctc_defs.svh is available to the design files.
 */
`default_nettype none
package mctc_pkg;
    // Timer 0/1 operating modes
    typedef enum logic [1:0] {
        MCTC_M13, MCTC_M16, MCTC_M8AR, MCTC_MSPLIT
    } mctc_mode_e;
    // Third timer modes
    typedef enum logic [1:0] {
        MCTC_T2_OFF, MCTC_T2_RELOAD, MCTC_T2_CAPTURE, MCTC_T2_BAUD
    } mctc_t2mode_e;
    // External pins after synchronisation
    typedef struct packed {
        logic cnt0;
        logic cnt1;
        logic cnt2;
        logic trig2;
        logic gate0;
        logic gate1;
    } mctc_pins_s;
    // Per-timer control view of the mode register nibble
    typedef struct packed {
        logic gate;
        logic ct;
        logic [1:0] mode;
    } mctc_tmode_s;
endpackage
`default_nettype wire

/* File: hw/mctc_cnt8.sv */
/*
 * One 8-bit count half with load, reload and carry out.
 * Assumes the caller supplies a one-cycle increment strobe.
 */
`default_nettype none
module mctc_cnt8 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Control
    input wire logic inc,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic [W-1:0] wrap_mask,
    // State
    output logic [W-1:0] cnt_q,
    output logic wrap
);
    // Wrap when every bit inside the mask is one
    assign wrap = inc && ((cnt_q & wrap_mask) == wrap_mask);

    // Count storage; load beats the increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (load) begin
                cnt_q <= load_val;
            end else if (inc) begin
                cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/mctc_top.sv */
/*
 * Three 16-bit timer/counters made of 8-bit halves, APB register access.
 * Assumes pins are asynchronous and the APB master is on pclk.
 */
`include "mctc_defs.svh"
`default_nettype none
module mctc_top (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic count_pin_two,
    input wire logic trigger_pin_two,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    // Events
    output logic baud_tick_one,
    output logic baud_tick_two
);
    // Software state
    logic [7:0] timer_control_reg_q;
    logic [7:0] timer_mode_reg_q;
    logic [7:0] third_timer_control_reg_q;
    logic [2:0] core_clock_divider_reg_q;
    logic [7:0] rcap_lo_q, rcap_hi_q;
    // Core clock and machine cycle phases
    logic [7:0] div_cnt_q;
    logic core_tick;
    logic [3:0] phase_q;
    logic sample_ph, update_ph;
    // Pin synchronisers
    mctc_pkg::mctc_pins_s pins_raw, meta_q, sync_q, samp_q, prev_q;
    // Counter halves
    logic [7:0] lo [3];
    logic [7:0] hi [3];
    logic [2:0] lo_wrap, hi_wrap;
    logic [2:0] lo_inc, hi_inc, lo_ld, hi_ld;
    logic [7:0] lo_ldv [3];
    logic [7:0] hi_ldv [3];
    logic [7:0] lo_mask [3];
    // Timer mode views
    mctc_pkg::mctc_tmode_s tm0, tm1;
    mctc_pkg::mctc_t2mode_e t2m;
    // Pending increments (edge seen, applied at update phase)
    logic [2:0] pend_q;
    logic pend_h0_q;
    logic trig_pend_q;
    // APB decode
    logic wr_en, rd_en;
    logic [31:0] rd_d;

    // Decode a mode nibble into its view
    function automatic mctc_pkg::mctc_tmode_s nib(input logic [3:0] n);
        nib = mctc_pkg::mctc_tmode_s'(n);
    endfunction

    assign tm0 = nib(timer_mode_reg_q[3:0]);
    assign tm1 = nib(timer_mode_reg_q[7:4]);

    // Third timer mode selection
    always_comb begin
        if (!third_timer_control_reg_q[`MCTC_T2_RUN]) begin
            t2m = mctc_pkg::MCTC_T2_OFF;
        end else if (third_timer_control_reg_q[`MCTC_T2_TBAUD] ||
                     third_timer_control_reg_q[`MCTC_T2_RBAUD]) begin
            t2m = mctc_pkg::MCTC_T2_BAUD;
        end else if (third_timer_control_reg_q[`MCTC_T2_CAP]) begin
            t2m = mctc_pkg::MCTC_T2_CAPTURE;
        end else begin
            t2m = mctc_pkg::MCTC_T2_RELOAD;
        end
    end

    // Core clock divider: divide by 2^setting
    // At-or-above compare: lowering the divider never waits for a wrap
    assign core_tick = (div_cnt_q >=
        8'((1 << core_clock_divider_reg_q) - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 8'h00;
        end else if (clk_en) begin
            div_cnt_q <= core_tick ? 8'h00 : div_cnt_q + 8'h01;
        end
    end

    // Twelve core periods make one machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 4'h0;
        end else if (clk_en && core_tick) begin
            phase_q <= (phase_q == 4'(`MCTC_CORE_PER_MC - 1)) ?
                4'h0 : phase_q + 4'h1;
        end
    end
    assign sample_ph = core_tick && (phase_q == `MCTC_PH_SAMPLE);
    assign update_ph = core_tick && (phase_q == `MCTC_PH_UPDATE);

    // Two-flop pin synchroniser, then one sample per machine cycle
    assign pins_raw = '{count_pin_zero, count_pin_one, count_pin_two,
                        trigger_pin_two, gate_pin_zero, gate_pin_one};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (clk_en) begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
        end
    end

    // Sample register and previous sample: edge needs two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q <= '0;
            prev_q <= '0;
        end else if (clk_en && sample_ph) begin
            samp_q <= sync_q;
            prev_q <= samp_q;
        end
    end

    // Count enables per timer, gate qualification on timers 0 and 1
    logic en0, en1, en2, en_h0;
    logic src0, src1, src2;
    assign en0 = timer_control_reg_q[`MCTC_CTRL_RUN0] &&
                 (!tm0.gate || samp_q.gate0);
    // Timer one halts in its own mode three
    // Split timer zero takes the run bit, so mode alone starts timer one
    assign en1 = (timer_control_reg_q[`MCTC_CTRL_RUN1] ||
                  tm0.mode == 2'(mctc_pkg::MCTC_MSPLIT)) &&
                 (!tm1.gate || samp_q.gate1) &&
                 (tm1.mode != 2'(mctc_pkg::MCTC_MSPLIT));
    assign en2 = (t2m != mctc_pkg::MCTC_T2_OFF);
    // Split high half: machine cycles on timer one run bit
    assign en_h0 = (tm0.mode == 2'(mctc_pkg::MCTC_MSPLIT)) &&
                   timer_control_reg_q[`MCTC_CTRL_RUN1];
    // Event source: one machine cycle or a seen falling edge
    assign src0 = tm0.ct ? (prev_q.cnt0 && !samp_q.cnt0) : 1'b1;
    assign src1 = tm1.ct ? (prev_q.cnt1 && !samp_q.cnt1) : 1'b1;
    assign src2 = third_timer_control_reg_q[`MCTC_T2_CT] ?
                  (prev_q.cnt2 && !samp_q.cnt2) : 1'b1;

    // Latch events at sample phase, apply at update phase
    logic trig_edge;
    assign trig_edge = prev_q.trig2 && !samp_q.trig2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 3'h0;
            pend_h0_q <= 1'b0;
            trig_pend_q <= 1'b0;
        end else if (clk_en && sample_ph) begin
            pend_q <= {en2 && src2, en1 && src1, en0 && src0};
            pend_h0_q <= en_h0;
            trig_pend_q <= trig_edge &&
                third_timer_control_reg_q[`MCTC_T2_EXEN];
        end else if (clk_en && update_ph) begin
            pend_q <= 3'h0;
            pend_h0_q <= 1'b0;
            trig_pend_q <= 1'b0;
        end
    end

    // APB strobes
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = wr_en && (a == off);
    endfunction

    // Counter halves: two 8-bit registers per timer
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_half
            mctc_cnt8 u_lo (
                .pclk(pclk), .presetn(presetn), .ce(clk_en),
                .inc(lo_inc[g]), .load(lo_ld[g]),
                .load_val(lo_ldv[g]), .wrap_mask(lo_mask[g]),
                .cnt_q(lo[g]), .wrap(lo_wrap[g]));
            mctc_cnt8 u_hi (
                .pclk(pclk), .presetn(presetn), .ce(clk_en),
                .inc(hi_inc[g]), .load(hi_ld[g]),
                .load_val(hi_ldv[g]), .wrap_mask(8'hFF),
                .cnt_q(hi[g]), .wrap(hi_wrap[g]));
        end
    endgenerate

    // Per-timer half steering by mode
    logic [2:0] ovf;
    logic ovf_h0, t2_reload;
    always_comb begin
        lo_inc = 3'h0;
        hi_inc = 3'h0;
        lo_ld = 3'h0;
        hi_ld = 3'h0;
        ovf = 3'h0;
        ovf_h0 = 1'b0;
        t2_reload = 1'b0;
        for (int t = 0; t < 3; t++) begin
            lo_ldv[t] = pwdata[7:0];
            hi_ldv[t] = pwdata[15:8];
            lo_mask[t] = 8'hFF;
        end
        for (int t = 0; t < 2; t++) begin
            mctc_pkg::mctc_tmode_s m;
            m = (t == 0) ? tm0 : tm1;
            lo_inc[t] = update_ph && pend_q[t];
            case (mctc_pkg::mctc_mode_e'(m.mode))
                mctc_pkg::MCTC_M13: begin
                    lo_mask[t] = 8'h1F;
                    hi_inc[t] = lo_wrap[t];
                    ovf[t] = lo_wrap[t] && hi_wrap[t];
                end
                mctc_pkg::MCTC_M16: begin
                    hi_inc[t] = lo_wrap[t];
                    ovf[t] = lo_wrap[t] && hi_wrap[t];
                end
                mctc_pkg::MCTC_M8AR: begin
                    lo_ld[t] = lo_wrap[t];
                    lo_ldv[t] = hi[t];
                    ovf[t] = lo_wrap[t];
                end
                default: begin
                    ovf[t] = (t == 0) && lo_wrap[t];
                    // Drop a pending event too: mode three must hold
                    if (t == 1) begin
                        lo_inc[t] = 1'b0;
                    end
                end
            endcase
        end
        // Split-mode high half of timer zero
        if (tm0.mode == 2'(mctc_pkg::MCTC_MSPLIT)) begin
            hi_inc[0] = update_ph && pend_h0_q;
            ovf_h0 = hi_wrap[0];
        end
        // Mode-0 prescaler carry: low five bits wrap into high half
        // Third timer, 16 bits
        lo_inc[2] = update_ph && pend_q[2] && en2;
        hi_inc[2] = lo_wrap[2];
        t2_reload = (lo_wrap[2] && hi_wrap[2]) ||
            (update_ph && trig_pend_q);
        if (t2m == mctc_pkg::MCTC_T2_RELOAD ||
            t2m == mctc_pkg::MCTC_T2_BAUD) begin
            lo_ld[2] = t2_reload;
            hi_ld[2] = t2_reload;
            lo_ldv[2] = rcap_lo_q;
            hi_ldv[2] = rcap_hi_q;
        end
        // Software writes win over counting
        if (hit(paddr, `MCTC_OFF_CNT0)) begin
            lo_ld[0] = 1'b1;
            hi_ld[0] = 1'b1;
            lo_ldv[0] = pwdata[7:0];
            hi_ldv[0] = pwdata[15:8];
        end
        if (hit(paddr, `MCTC_OFF_CNT1)) begin
            lo_ld[1] = 1'b1;
            hi_ld[1] = 1'b1;
            lo_ldv[1] = pwdata[7:0];
            hi_ldv[1] = pwdata[15:8];
        end
        if (hit(paddr, `MCTC_OFF_CNT2)) begin
            lo_ld[2] = 1'b1;
            hi_ld[2] = 1'b1;
            lo_ldv[2] = pwdata[7:0];
            hi_ldv[2] = pwdata[15:8];
        end
    end

    // Timer control: run bits and sticky overflow flags; set wins
    logic set_of0, set_of1;
    assign set_of0 = ovf[0];
    assign set_of1 = ovf[1] || ovf_h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg_q <= `MCTC_RST_BYTE;
        end else if (clk_en) begin
            if (hit(paddr, `MCTC_OFF_CTRL)) begin
                timer_control_reg_q <= pwdata[7:0];
            end
            if (set_of0) begin
                timer_control_reg_q[`MCTC_CTRL_OVF0] <= 1'b1;
            end
            if (set_of1) begin
                timer_control_reg_q[`MCTC_CTRL_OVF1] <= 1'b1;
            end
        end
    end

    // Mode and divider registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_mode_reg_q <= `MCTC_RST_BYTE;
            core_clock_divider_reg_q <= `MCTC_RST_DIV;
        end else if (clk_en) begin
            if (hit(paddr, `MCTC_OFF_MODE)) begin
                timer_mode_reg_q <= pwdata[7:0];
            end
            if (hit(paddr, `MCTC_OFF_CLKDIV)) begin
                core_clock_divider_reg_q <= pwdata[2:0];
            end
        end
    end

    // Third timer control with its two sticky flags
    logic t2_ovf_set, t2_ext_set, t2_cap;
    assign t2_ovf_set = lo_wrap[2] && hi_wrap[2] &&
                        (t2m != mctc_pkg::MCTC_T2_BAUD);
    assign t2_ext_set = update_ph && trig_pend_q;
    assign t2_cap = t2_ext_set && (t2m == mctc_pkg::MCTC_T2_CAPTURE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            third_timer_control_reg_q <= `MCTC_RST_BYTE;
        end else if (clk_en) begin
            if (hit(paddr, `MCTC_OFF_T2CTRL)) begin
                third_timer_control_reg_q <= pwdata[7:0];
            end
            if (t2_ovf_set) begin
                third_timer_control_reg_q[`MCTC_T2_OVF] <= 1'b1;
            end
            if (t2_ext_set) begin
                third_timer_control_reg_q[`MCTC_T2_EXF] <= 1'b1;
            end
        end
    end

    // Reload/capture registers; capture beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcap_lo_q <= `MCTC_RST_BYTE;
            rcap_hi_q <= `MCTC_RST_BYTE;
        end else if (clk_en) begin
            if (t2_cap) begin
                rcap_lo_q <= lo[2];
                rcap_hi_q <= hi[2];
            end else if (hit(paddr, `MCTC_OFF_RCAP)) begin
                rcap_lo_q <= pwdata[7:0];
                rcap_hi_q <= pwdata[15:8];
            end
        end
    end

    // Read mux
    always_comb begin
        case (paddr)
            `MCTC_OFF_CTRL: rd_d = {24'h0, timer_control_reg_q};
            `MCTC_OFF_MODE: rd_d = {24'h0, timer_mode_reg_q};
            `MCTC_OFF_T2CTRL: rd_d = {24'h0, third_timer_control_reg_q};
            `MCTC_OFF_CNT0: rd_d = {16'h0, hi[0], lo[0]};
            `MCTC_OFF_CNT1: rd_d = {16'h0, hi[1], lo[1]};
            `MCTC_OFF_CNT2: rd_d = {16'h0, hi[2], lo[2]};
            `MCTC_OFF_RCAP: rd_d = {16'h0, rcap_hi_q, rcap_lo_q};
            `MCTC_OFF_CLKDIV: rd_d = {29'h0, core_clock_divider_reg_q};
            default: rd_d = 32'h0;
        endcase
    end

    // APB answer: read data caught in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            if (rd_en) begin
                prdata <= rd_d;
            end
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    // Baud ticks: overflow pulses for the serial port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_tick_one <= 1'b0;
            baud_tick_two <= 1'b0;
        end else if (clk_en) begin
            baud_tick_one <= ovf[1];
            baud_tick_two <= lo_wrap[2] && hi_wrap[2] &&
                             (t2m == mctc_pkg::MCTC_T2_BAUD);
        end
    end
endmodule
`default_nettype wire

/* File: tb/mctc_checker.sv */
/* Port checker for the timer block: APB answer and event tick timing.
   Assumes clk_en is held high and the register map of mctc_defs. */
`include "mctc_defs.svh"
`default_nettype none
module mctc_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events
    input wire logic baud_tick_one,
    input wire logic baud_tick_two
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ok; // Write taken at this edge
    logic [7:0] ctrl_q, mode_q, t2_q; // Shadows of the control and mode registers
    logic t1_ok, t2_ok; // Ticks may legally appear
    assign wr_ok = psel && penable && pready && pwrite;
    // Shadow copies follow software writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            mode_q <= 8'h00;
            t2_q <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == `MCTC_OFF_CTRL) ctrl_q <= pwdata[7:0];
            if (paddr == `MCTC_OFF_MODE) mode_q <= pwdata[7:0];
            if (paddr == `MCTC_OFF_T2CTRL) t2_q <= pwdata[7:0];
        end
    end
    // Timer 1 runs outside its mode 3; run bit taken over in split mode
    assign t1_ok = mode_q[5:4] != 2'h3 &&
        (ctrl_q[1] || mode_q[1:0] == 2'h3);
    assign t2_ok = t2_q[2] && (t2_q[4] || t2_q[5]);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        psel && penable && pready && !pwrite;
    endsequence
    a_ack_next: assert property (s_setup |=> pready)
        else $error("no answer in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_no_error: assert property (pready |-> !pslverr)
        else $error("error response seen");
    a_upper_zero: assert property (
        s_read ##0 (paddr >= `MCTC_OFF_CNT0 && paddr <= `MCTC_OFF_RCAP)
        |-> prdata[31:16] == 16'h0000) else $error("count upper bits set");
    a_unmapped_zero: assert property (
        s_read ##0 paddr >= 12'h020 |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_tick1_gap: assert property (
        baud_tick_one |=> !baud_tick_one [*8])
        else $error("timer 1 ticks faster than a machine cycle");
    a_tick2_gap: assert property (
        baud_tick_two |=> !baud_tick_two [*8])
        else $error("timer 2 ticks faster than a machine cycle");
    a_tick1_cause: assert property (
        baud_tick_one |-> t1_ok || $past(t1_ok))
        else $error("timer 1 tick while held");
    a_tick2_cause: assert property (
        baud_tick_two |-> t2_ok || $past(t2_ok))
        else $error("timer 2 tick outside running baud mode");
endmodule
bind mctc_top mctc_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick_one(baud_tick_one),
    .baud_tick_two(baud_tick_two));
`default_nettype wire

/* File: tb/mctc_pin_model.sv */
/* External count, trigger and gate sources for the timer block.
   Assumes a machine cycle of MC pclk periods; pins idle high. */
`default_nettype none
module mctc_pin_model #(
    parameter int MC = 12
) (
    // Clock
    input wire logic pclk,
    // Pins: 0 cnt0, 1 cnt1, 2 cnt2, 3 trigger, 4 gate0, 5 gate1
    output logic [5:0] pin_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups hold every pin high when not driven low
    initial pin_q = 6'h3F;
    // Falling-edge train; each level held two machine cycles
    task automatic pulse(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            pin_q[sel] <= 1'b0;
            repeat (2 * MC) @(posedge pclk);
            pin_q[sel] <= 1'b1;
            repeat (2 * MC) @(posedge pclk);
        end
    endtask
    // Static level, for gate pins
    task automatic set_pin(input int sel, input logic v);
        @(posedge pclk);
        pin_q[sel] <= v;
    endtask
endmodule
`default_nettype wire

/* File: tb/machine_cycle_timer_counters_tb.sv */
/* Self-checking bench for the timer block over APB.
   Assumes divider 0 gives a 12 pclk machine cycle. */
`include "mctc_defs.svh"
`default_nettype none
module machine_cycle_timer_counters_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, tick1, tick2;
    logic [5:0] pins_w; // Pin levels from the source model
    logic [15:0] d; // Count moved over ten machine cycles
    int error_cnt = 0;
    int checked = 0;
    int t2_ticks = 0;
    int t1_ticks = 0;
    // Presets, masks and results of the mode 0/1/2 overflow runs
    logic [15:0] pre [3] = '{16'hFF1E, 16'hFFFE, 16'hF0FE};
    logic [15:0] msk [3] = '{16'hFF00, 16'hFFF8, 16'hFFF0};
    logic [15:0] res [3] = '{16'h0000, 16'h0000, 16'hF0F0};
    mctc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_pin_zero(pins_w[0]),
        .count_pin_one(pins_w[1]), .count_pin_two(pins_w[2]),
        .trigger_pin_two(pins_w[3]), .gate_pin_zero(pins_w[4]),
        .gate_pin_one(pins_w[5]), .baud_tick_one(tick1),
        .baud_tick_two(tick2));
    mctc_pin_model #(.MC(12)) pins (.pclk(pclk), .pin_q(pins_w));
    // 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Count timer 2 and timer 1 event ticks
    always @(posedge pclk) if (tick2 === 1'b1) t2_ticks++;
    always @(posedge pclk) if (tick1 === 1'b1) t1_ticks++;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("pready", 0, 1);
            close_out();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        xfer(1'b1, a, wd, q);
    endtask
    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0, q);
    endtask
    // Two reads exactly ten machine cycles apart
    task automatic delta(input logic [11:0] a);
        logic [15:0] x;
        rd(a);
        x = q[15:0];
        repeat (117) @(posedge pclk);
        rd(a);
        d = q[15:0] - x;
    endtask
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        rd(`MCTC_OFF_CTRL); chk("ctrl", q, 32'h0);
        rd(`MCTC_OFF_CLKDIV); chk("clkdiv", q, 32'h3);
        wr(12'h020, 32'hFF); rd(12'h020); chk("unmapped", q, 32'h0);
        wr(`MCTC_OFF_CLKDIV, 32'h0);
        $display("test reset done");
        // Gated timer: run leaves count, gate pin stops and starts it
        pins.set_pin(4, 1'b0);
        wr(`MCTC_OFF_CNT0, 32'h1234); wr(`MCTC_OFF_MODE, 32'h09);
        wr(`MCTC_OFF_CTRL, 32'h1);
        rd(`MCTC_OFF_CNT0); chk("run keeps", q, 32'h1234);
        delta(`MCTC_OFF_CNT0); chk("gated", d, 16'h0);
        pins.set_pin(4, 1'b1);
        repeat (24) @(posedge pclk);
        delta(`MCTC_OFF_CNT0); chk("rate", d, 16'hA);
        $display("test gate done");
        // Overflow in modes 0, 1 and 2
        for (int m = 0; m < 3; m++) begin
            wr(`MCTC_OFF_CTRL, 32'h0); wr(`MCTC_OFF_MODE, m);
            wr(`MCTC_OFF_CNT0, pre[m]); wr(`MCTC_OFF_CTRL, 32'h1);
            repeat (60) @(posedge pclk);
            rd(`MCTC_OFF_CTRL); chk("ovf0", q & 32'h30, 32'h10);
            rd(`MCTC_OFF_CNT0);
            chk("wrap", q[15:0] & msk[m], res[m]);
        end
        $display("test modes done");
        // Counter function on pin one
        wr(`MCTC_OFF_CTRL, 32'h0); wr(`MCTC_OFF_MODE, 32'h50);
        wr(`MCTC_OFF_CNT1, 32'h0); wr(`MCTC_OFF_CTRL, 32'h2);
        pins.pulse(1, 5);
        repeat (36) @(posedge pclk);
        rd(`MCTC_OFF_CNT1); chk("edges", q, 32'h5);
        $display("test counter done");
        // Timer 1 reload, hold in mode 3, split timer 0
        wr(`MCTC_OFF_CTRL, 32'h0); wr(`MCTC_OFF_MODE, 32'h20);
        wr(`MCTC_OFF_CNT1, 32'hFFFF); wr(`MCTC_OFF_CTRL, 32'h2);
        repeat (36) @(posedge pclk);
        rd(`MCTC_OFF_CTRL); chk("ovf1", q & 32'h30, 32'h20);
        chk("t1 tick", t1_ticks != 0, 1);
        wr(`MCTC_OFF_MODE, 32'h30);
        delta(`MCTC_OFF_CNT1); chk("t1 hold", d, 16'h0);
        wr(`MCTC_OFF_MODE, 32'h13); wr(`MCTC_OFF_CNT0, 32'h0);
        wr(`MCTC_OFF_CTRL, 32'h2);
        delta(`MCTC_OFF_CNT0); chk("split", d, 16'h0A00);
        delta(`MCTC_OFF_CNT1); chk("t1 runs", d, 16'hA);
        $display("test split done");
        // Timer 2 reload, capture, baud and stop
        wr(`MCTC_OFF_CTRL, 32'h0);
        wr(`MCTC_OFF_RCAP, 32'hFFF0); wr(`MCTC_OFF_CNT2, 32'hFFFE);
        wr(`MCTC_OFF_T2CTRL, 32'h04);
        repeat (60) @(posedge pclk);
        rd(`MCTC_OFF_T2CTRL); chk("ovf2", q & 32'hC0, 32'h80);
        rd(`MCTC_OFF_CNT2); chk("reload", q & 32'hFFF0, 32'hFFF0);
        wr(`MCTC_OFF_T2CTRL, 32'h0); wr(`MCTC_OFF_RCAP, 32'h0);
        wr(`MCTC_OFF_CNT2, 32'h1000); wr(`MCTC_OFF_T2CTRL, 32'h0D);
        pins.pulse(3, 1);
        repeat (36) @(posedge pclk);
        rd(`MCTC_OFF_T2CTRL); chk("extf", q & 32'hC0, 32'h40);
        rd(`MCTC_OFF_RCAP); chk("capture", q & 32'hFF00, 32'h1000);
        wr(`MCTC_OFF_T2CTRL, 32'h0); wr(`MCTC_OFF_RCAP, 32'hFFF0);
        wr(`MCTC_OFF_CNT2, 32'hFFFE); wr(`MCTC_OFF_T2CTRL, 32'h14);
        repeat (60) @(posedge pclk);
        rd(`MCTC_OFF_T2CTRL); chk("baud ovf", q & 32'hC0, 32'h0);
        chk("baud tick", t2_ticks != 0, 1);
        wr(`MCTC_OFF_T2CTRL, 32'h10);
        delta(`MCTC_OFF_CNT2); chk("t2 stop", d, 16'h0);
        $display("test timer2 done");
        close_out();
    end
endmodule
`default_nettype wire
